// ### vafe_pkg.sv
/*
 * vafe_pkg: register indices, field positions, reset values, timing
 * constants and the clamp generator state type of the video front end
 * configuration slice.
 * assumes: a 200 mhz system clock; registers are 8 bits wide and sit in
 * the low byte of aligned 32-bit apb words (byte address = 4 * index).
 */
package vafe_pkg;

    //////////////////////////////////////////////////////////////////////
    // clock and timing
    localparam int CLOCK_PERIOD_NS = 5; // 200 mhz
    // silence on a sync line longer than this marks it inactive
    localparam int ACTIVITY_WINDOW_NS = 20480;
    localparam int ACTIVITY_WINDOW_CYCLES =
        ACTIVITY_WINDOW_NS / CLOCK_PERIOD_NS; // longest time, rounded down
    // width of the internally generated clamp pulse
    localparam int CLAMP_WIDTH_NS = 80;
    localparam int CLAMP_WIDTH_CYCLES =
        (CLAMP_WIDTH_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

    //////////////////////////////////////////////////////////////////////
    // bus geometry
    localparam int PADDR_WIDTH = 12;
    localparam int REG_WIDTH = 8;

    // register indices (byte address is four times the index)
    localparam logic [7:0] IDX_INPUT_CONFIG = 8'h10;
    localparam logic [7:0] IDX_SYNC_SOURCE_SELECTION = 8'h11;
    localparam logic [7:0] IDX_RED_GAIN_HIGH = 8'h12;
    localparam logic [7:0] IDX_RED_GAIN_LOW = 8'h13;
    localparam logic [7:0] IDX_GREEN_GAIN_HIGH = 8'h14;
    localparam logic [7:0] IDX_GREEN_GAIN_LOW = 8'h15;
    localparam logic [7:0] IDX_BLUE_GAIN_HIGH = 8'h16;
    localparam logic [7:0] IDX_BLUE_GAIN_LOW = 8'h17;
    localparam logic [7:0] IDX_RED_OFFSET_HIGH = 8'h18;
    localparam logic [7:0] IDX_RED_OFFSET_LOW = 8'h19;
    localparam logic [7:0] IDX_GREEN_OFFSET_HIGH = 8'h1a;
    localparam logic [7:0] IDX_GREEN_OFFSET_LOW = 8'h1b;
    localparam logic [7:0] IDX_BLUE_OFFSET_HIGH = 8'h1c;
    localparam logic [7:0] IDX_BLUE_OFFSET_LOW = 8'h1d;
    localparam logic [7:0] IDX_BLACK_LEVEL_CONTROL = 8'h30;
    localparam logic [7:0] IDX_INPUT_CHARACTERISTICS = 8'h31;

    // contiguous configuration block 0x10..0x1d
    localparam logic [7:0] CFG_FIRST = IDX_INPUT_CONFIG;
    localparam int CFG_COUNT = 14;
    // positions of a channel's words inside the block
    localparam int CFG_GAIN_BASE = 2;   // high at base + 2c, low next
    localparam int CFG_OFFSET_BASE = 8; // high at base + 2c, low next
    localparam int CHANNELS = 3;        // red, green, blue

    // reset values per configuration entry
    localparam logic [7:0] CFG_RESET [CFG_COUNT] = '{
        8'h00, 8'h00, 8'h55, 8'h00, 8'h55, 8'h00, 8'h55,
        8'h00, 8'h80, 8'h00, 8'h80, 8'h00, 8'h80, 8'h00};
    // implemented bits per entry; the rest read as zero
    localparam logic [7:0] CFG_MASK [CFG_COUNT] = '{
        8'hff, 8'h07, 8'hff, 8'hc0, 8'hff, 8'hc0, 8'hff,
        8'hc0, 8'hff, 8'hc0, 8'hff, 8'hc0, 8'hff, 8'hc0};
    localparam logic [7:0] BLACK_LEVEL_RESET = 8'h00;

    //////////////////////////////////////////////////////////////////////
    // field positions
    localparam int CLAMP_SOURCE_BIT = 6;    // input config
    localparam int CLAMP_POLARITY_BIT = 7;  // input config
    localparam int SYNC_MANUAL_BIT = 0;     // sync source selection
    localparam int HSYNC_SOURCE_BIT = 1;
    localparam int VSYNC_SOURCE_BIT = 2;
    localparam int LOOP_ENABLE_BIT = 0;     // black level control
    // input characteristics status bits
    localparam int STAT_HSYNC_SOG_BIT = 0;
    localparam int STAT_VSYNC_SEP_BIT = 1;
    localparam int STAT_ACTIVITY_LSB = 2;   // four activity flags

    // sync pin vector order
    localparam int PIN_HSYNC = 0;
    localparam int PIN_VSYNC = 1;
    localparam int PIN_SOG = 2;
    localparam int PIN_SEP = 3;
    localparam int PIN_CLAMP = 4;
    localparam int PIN_COUNT = 5;
    localparam int SYNC_COUNT = 4;

    localparam logic [9:0] OFFSET_MIDSCALE = 10'h200;

    // internal clamp generator
    typedef enum logic [0:0] {
        CLAMP_IDLE = 1'b0,
        CLAMP_ON = 1'b1
    } vafe_clamp_state_type;

endpackage : vafe_pkg

// ### vafe_activity.sv
/*
 * vafe_activity: watches one synchronised sync line and flags it active
 * while edges keep arriving within the activity window.
 * assumes: the input is already synchronised to i_clock.
 */
`timescale 1ns/100ps
module vafe_activity (
    input wire logic i_clock,
    input wire logic i_srst,
    input wire logic i_line,
    output logic o_active
);

    localparam logic [12:0] WINDOW =
        13'(vafe_pkg::ACTIVITY_WINDOW_CYCLES);

    logic last;          // previous line level
    logic [12:0] quiet;  // cycles since the last edge, saturating
    wire edge_seen = i_line ^ last;

    // quiet-cycle counter; saturation keeps a dead line from wrapping to active
    always_ff @(posedge i_clock)
    begin
        if (i_srst)
        begin
            last <= 1'b0;
            quiet <= WINDOW;
            o_active <= 1'b0;
        end
        else
        begin
            last <= i_line;
            if (edge_seen)
                quiet <= 13'h0000;
            else if (quiet != WINDOW)
                quiet <= quiet + 13'h0001;
            o_active <= edge_seen | (quiet != WINDOW);
        end
    end

endmodule : vafe_activity

// ### vafe_channel.sv
/*
 * vafe_channel: forms one colour channel's gain code and offset words
 * from its high and low configuration bytes.
 * assumes: bytes come from registers on the same clock.
 */
`timescale 1ns/100ps
module vafe_channel (
    input wire logic i_clock,
    input wire logic i_srst,
    input wire logic [7:0] i_gain_high,
    input wire logic [7:0] i_gain_low,
    input wire logic [7:0] i_offset_high,
    input wire logic [7:0] i_offset_low,
    input wire logic i_loop_enable,
    output logic [9:0] o_gain_code,
    output logic [9:0] o_offset_dac,
    output logic [9:0] o_digital_offset
);

    // ten-bit words: high byte then bits 7:6 of the low byte
    wire [9:0] gain_word = {i_gain_high, i_gain_low[7:6]};
    wire [9:0] offset_word = {i_offset_high, i_offset_low[7:6]};

    // analog gain is 0.5 + code/682 v/v; the code alone leaves here
    // with the loop off the word feeds the dac directly
    wire [9:0] next_offset_dac =
        i_loop_enable ? vafe_pkg::OFFSET_MIDSCALE : offset_word;
    // offset binary to two's complement is a flip of the top bit
    wire [9:0] next_digital_offset =
        i_loop_enable ? {~offset_word[9], offset_word[8:0]} : 10'h000;

    // output registers
    always_ff @(posedge i_clock)
    begin
        if (i_srst)
        begin
            o_gain_code <= 10'h154;
            o_offset_dac <= vafe_pkg::OFFSET_MIDSCALE;
            o_digital_offset <= 10'h000;
        end
        else
        begin
            o_gain_code <= gain_word;
            o_offset_dac <= next_offset_dac;
            o_digital_offset <= next_digital_offset;
        end
    end

endmodule : vafe_channel

// ### vafe_regs.sv
/*
 * vafe_regs: apb register slice of the triple channel video front end:
 * clamp source and polarity, sync source selection (automatic or manual),
 * per-channel gain and offset words and the black level loop switch.
 * assumes: an apb master on i_clock; sync and clamp pins are asynchronous
 * and are synchronised here; the sync separator output arrives as a pin.
 */
`timescale 1ns/100ps

// Behaviour
// - clamp polarity bit 7: 0 high, 1 low
// - clamp source bit 6: internal or external
// - automatic sync choice, reported in status register
// - manual mode uses only bits 1 and 2
// - hsync bit 1: pin or sync on green
// - vsync bit 2: pin or sync separator
// - gain code drives 0.5 + code/682
// - gain is high byte plus low bits 7:6
// - loop off: offset word drives dac
// - loop on: offset is offset-binary digital value
// - offset word low bits from bits 7:6
module vafe_regs (
    input wire logic I_CLOCK,
    input wire logic I_SRST,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [11:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    input wire logic [3:0] I_PSTRB,
    output logic [31:0] O_PRDATA,
    output logic O_PREADY,
    output logic O_PSLVERR,
    input wire logic I_HSYNC,
    input wire logic I_VSYNC,
    input wire logic I_SYNC_ON_GREEN_INPUT,
    input wire logic I_SYNC_SEPARATOR,
    input wire logic I_EXTERNAL_CLAMP,
    output logic O_HSYNC,
    output logic O_VSYNC,
    output logic O_CLAMP,
    output logic [9:0] O_RED_GAIN_CODE,
    output logic [9:0] O_GREEN_GAIN_CODE,
    output logic [9:0] O_BLUE_GAIN_CODE,
    output logic [9:0] O_RED_OFFSET_DAC,
    output logic [9:0] O_GREEN_OFFSET_DAC,
    output logic [9:0] O_BLUE_OFFSET_DAC,
    output logic [9:0] O_RED_DIGITAL_OFFSET,
    output logic [9:0] O_GREEN_DIGITAL_OFFSET,
    output logic [9:0] O_BLUE_DIGITAL_OFFSET
);

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    // raw pins gathered so one loop synchronises them all
    wire [vafe_pkg::PIN_COUNT-1:0] pins_raw = {
        I_EXTERNAL_CLAMP, I_SYNC_SEPARATOR, I_SYNC_ON_GREEN_INPUT,
        I_VSYNC, I_HSYNC};
    logic [vafe_pkg::PIN_COUNT-1:0] pins_meta; // first stage, read by sync
    logic [vafe_pkg::PIN_COUNT-1:0] pins_sync; // safe to use

    genvar p;
    generate
        for (p = 0; p < vafe_pkg::PIN_COUNT; p = p + 1)
        begin : g_pin_sync
            // two flops; only the second stage feeds any logic
            always_ff @(posedge I_CLOCK)
            begin
                if (I_SRST)
                begin
                    pins_meta[p] <= 1'b0;
                    pins_sync[p] <= 1'b0;
                end
                else
                begin
                    pins_meta[p] <= pins_raw[p];
                    pins_sync[p] <= pins_meta[p];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // apb decode

    wire [7:0] bus_idx = I_PADDR[9:2];          // register index
    wire bus_aligned = (I_PADDR[1:0] == 2'b00); // word aligned
    wire bus_high_zero = (I_PADDR[11:10] == 2'b00); // inside the map
    wire setup_phase = I_PSEL & ~I_PENABLE;     // first cycle of transfer
    wire access_done = I_PSEL & I_PENABLE & O_PREADY; // completes here
    wire [7:0] cfg_rel = bus_idx - vafe_pkg::CFG_FIRST; // offset in block
    wire in_cfg = (bus_idx >= vafe_pkg::CFG_FIRST) &&
        (cfg_rel < 8'(vafe_pkg::CFG_COUNT));
    wire hit_loop = (bus_idx == vafe_pkg::IDX_BLACK_LEVEL_CONTROL);
    wire hit_status = (bus_idx == vafe_pkg::IDX_INPUT_CHARACTERISTICS);
    // any decoded register at a legal, aligned address
    wire mapped = bus_aligned & bus_high_zero &
        (in_cfg | hit_loop | hit_status);
    // writes land only at completion and only through byte lane 0
    wire wr_fire = access_done & I_PWRITE & mapped & I_PSTRB[0];

    ////////////////////////////////////////////////////////////////////////
    // configuration storage

    logic [7:0] cfg [vafe_pkg::CFG_COUNT]; // block 0x10..0x1d
    logic [7:0] black_level;               // loop switch register
    logic [7:0] input_status;              // read only, chosen muxes

    genvar r;
    generate
        for (r = 0; r < vafe_pkg::CFG_COUNT; r = r + 1)
        begin : g_cfg
            // unused bits are masked away so they always read zero
            wire hit = wr_fire & in_cfg & (cfg_rel == 8'(r));
            always_ff @(posedge I_CLOCK)
            begin
                if (I_SRST)
                    cfg[r] <= vafe_pkg::CFG_RESET[r];
                else if (hit)
                    cfg[r] <= I_PWDATA[7:0] & vafe_pkg::CFG_MASK[r];
            end
        end
    endgenerate

    // black level loop switch, only bit 0 is kept
    always_ff @(posedge I_CLOCK)
    begin
        if (I_SRST)
            black_level <= vafe_pkg::BLACK_LEVEL_RESET;
        else if (wr_fire & hit_loop)
            black_level <= {7'h00, I_PWDATA[vafe_pkg::LOOP_ENABLE_BIT]};
    end

    // named views of the fields that steer the logic
    wire [7:0] input_config = cfg[0];
    wire [7:0] sync_select = cfg[1];
    wire clamp_external = input_config[vafe_pkg::CLAMP_SOURCE_BIT];
    wire clamp_active_low = input_config[vafe_pkg::CLAMP_POLARITY_BIT];
    wire sync_manual = sync_select[vafe_pkg::SYNC_MANUAL_BIT];
    wire manual_hsync_sog = sync_select[vafe_pkg::HSYNC_SOURCE_BIT];
    wire manual_vsync_sep = sync_select[vafe_pkg::VSYNC_SOURCE_BIT];
    wire loop_enable = black_level[vafe_pkg::LOOP_ENABLE_BIT];

    ////////////////////////////////////////////////////////////////////////
    // apb read path and answer

    // read mux; anything unmapped reads zero
    wire [7:0] rd_byte =
        (!mapped) ? 8'h00 :
        in_cfg ? cfg[cfg_rel[3:0]] :
        hit_loop ? black_level :
        input_status;

    // the answer is prepared in the setup cycle, so every transfer takes
    // exactly one access cycle and read data come from a flop
    always_ff @(posedge I_CLOCK)
    begin
        if (I_SRST)
        begin
            O_PREADY <= 1'b0;
            O_PRDATA <= 32'h0000_0000;
            O_PSLVERR <= 1'b0;
        end
        else if (setup_phase)
        begin
            O_PREADY <= 1'b1;
            O_PRDATA <= I_PWRITE ? 32'h0000_0000 : {24'h00_0000, rd_byte};
            O_PSLVERR <= ~mapped;
        end
        else if (access_done)
        begin
            O_PREADY <= 1'b0;
            O_PSLVERR <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sync activity and source selection

    logic [vafe_pkg::SYNC_COUNT-1:0] activity; // per sync line

    genvar s;
    generate
        for (s = 0; s < vafe_pkg::SYNC_COUNT; s = s + 1)
        begin : g_activity
            vafe_activity u_activity (
                .i_clock(I_CLOCK),
                .i_srst(I_SRST),
                .i_line(pins_sync[s]),
                .o_active(activity[s])
            );
        end
    endgenerate

    // automatic choice prefers the dedicated pin while it toggles
    wire auto_hsync_sog = ~activity[vafe_pkg::PIN_HSYNC] &
        activity[vafe_pkg::PIN_SOG];
    wire auto_vsync_sep = ~activity[vafe_pkg::PIN_VSYNC] &
        activity[vafe_pkg::PIN_SEP];
    // manual mode ignores activity entirely
    wire use_sog = sync_manual ? manual_hsync_sog : auto_hsync_sog;
    wire use_sep = sync_manual ? manual_vsync_sep : auto_vsync_sep;
    wire next_hsync = use_sog ? pins_sync[vafe_pkg::PIN_SOG] :
        pins_sync[vafe_pkg::PIN_HSYNC];
    wire next_vsync = use_sep ? pins_sync[vafe_pkg::PIN_SEP] :
        pins_sync[vafe_pkg::PIN_VSYNC];
    // status shows the muxes in use plus raw activity
    wire [7:0] next_status = {2'b00, activity, use_sep, use_sog};

    // selected syncs and the status register
    always_ff @(posedge I_CLOCK)
    begin
        if (I_SRST)
        begin
            O_HSYNC <= 1'b0;
            O_VSYNC <= 1'b0;
            input_status <= 8'h00;
        end
        else
        begin
            O_HSYNC <= next_hsync;
            O_VSYNC <= next_vsync;
            input_status <= next_status;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // clamp generation

    localparam logic [7:0] CLAMP_LAST =
        8'(vafe_pkg::CLAMP_WIDTH_CYCLES - 1);

    vafe_pkg::vafe_clamp_state_type clamp_state; // internal pulse state
    vafe_pkg::vafe_clamp_state_type next_clamp_state;
    logic [7:0] clamp_count;    // cycles of the pulse so far
    logic hsync_last;           // for trailing edge detection
    // the clamp starts on the trailing edge of the chosen hsync
    wire hsync_trailing = hsync_last & ~O_HSYNC;

    // pulse state machine; a new edge during a pulse is ignored
    always_comb
    begin
        next_clamp_state = clamp_state;
        case (clamp_state)
            vafe_pkg::CLAMP_IDLE:
                if (hsync_trailing)
                    next_clamp_state = vafe_pkg::CLAMP_ON;
            vafe_pkg::CLAMP_ON:
                if (clamp_count == CLAMP_LAST)
                    next_clamp_state = vafe_pkg::CLAMP_IDLE;
            default:
                next_clamp_state = vafe_pkg::CLAMP_IDLE;
        endcase
    end

    // external clamp turned into an active high level
    wire ext_clamp = pins_sync[vafe_pkg::PIN_CLAMP] ^ clamp_active_low;
    wire int_clamp = (clamp_state == vafe_pkg::CLAMP_ON);
    wire next_clamp = clamp_external ? ext_clamp : int_clamp;

    // state, counter and clamp output
    always_ff @(posedge I_CLOCK)
    begin
        if (I_SRST)
        begin
            clamp_state <= vafe_pkg::CLAMP_IDLE;
            clamp_count <= 8'h00;
            hsync_last <= 1'b0;
            O_CLAMP <= 1'b0;
        end
        else
        begin
            clamp_state <= next_clamp_state;
            clamp_count <= int_clamp ? clamp_count + 8'h01 : 8'h00;
            hsync_last <= O_HSYNC;
            O_CLAMP <= next_clamp;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // colour channels

    logic [9:0] gain_code [vafe_pkg::CHANNELS];
    logic [9:0] offset_dac [vafe_pkg::CHANNELS];
    logic [9:0] digital_offset [vafe_pkg::CHANNELS];

    genvar c;
    generate
        for (c = 0; c < vafe_pkg::CHANNELS; c = c + 1)
        begin : g_channel
            // gain words sit at 0x12 + 2c, offset words at 0x18 + 2c
            vafe_channel u_channel (
                .i_clock(I_CLOCK),
                .i_srst(I_SRST),
                .i_gain_high(cfg[vafe_pkg::CFG_GAIN_BASE + 2 * c]),
                .i_gain_low(cfg[vafe_pkg::CFG_GAIN_BASE + 2 * c + 1]),
                .i_offset_high(cfg[vafe_pkg::CFG_OFFSET_BASE + 2 * c]),
                .i_offset_low(cfg[vafe_pkg::CFG_OFFSET_BASE + 2 * c + 1]),
                .i_loop_enable(loop_enable),
                .o_gain_code(gain_code[c]),
                .o_offset_dac(offset_dac[c]),
                .o_digital_offset(digital_offset[c])
            );
        end
    endgenerate

    // channel order is red, green, blue
    assign O_RED_GAIN_CODE = gain_code[0];
    assign O_GREEN_GAIN_CODE = gain_code[1];
    assign O_BLUE_GAIN_CODE = gain_code[2];
    assign O_RED_OFFSET_DAC = offset_dac[0];
    assign O_GREEN_OFFSET_DAC = offset_dac[1];
    assign O_BLUE_OFFSET_DAC = offset_dac[2];
    assign O_RED_DIGITAL_OFFSET = digital_offset[0];
    assign O_GREEN_DIGITAL_OFFSET = digital_offset[1];
    assign O_BLUE_DIGITAL_OFFSET = digital_offset[2];

endmodule : vafe_regs

// ### vafe_regs_sva.sv
/* vafe_regs_sva: checks on apb and red channel ports.
   assumes: bound into vafe_regs; sync reset high. */
`timescale 1ns/100ps
module vafe_regs_sva (
    input wire logic I_CLOCK,
    input wire logic I_SRST,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [11:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    input wire logic [3:0] I_PSTRB,
    input wire logic [31:0] O_PRDATA,
    input wire logic O_PREADY,
    input wire logic O_PSLVERR,
    input wire logic [9:0] O_RED_GAIN_CODE,
    input wire logic [9:0] O_RED_OFFSET_DAC
);
    default clocking @(posedge I_CLOCK); endclocking
    default disable iff (I_SRST);
    // write stored at this edge
    wire wr = I_PSEL & I_PENABLE & I_PWRITE & O_PREADY & I_PSTRB[0];
    wire a_hi = I_PADDR == {2'b00, vafe_pkg::IDX_RED_GAIN_HIGH, 2'b00};
    wire a_lo = I_PADDR == {2'b00, vafe_pkg::IDX_RED_GAIN_LOW, 2'b00};
    ////////////////////////////////////////////////////////////////////
    property p_ready_pulse;
        O_PREADY |=> !O_PREADY;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse)
        else $error("pready too long");
    property p_zero_wait;
        I_PSEL && !I_PENABLE |=> O_PREADY;
    endproperty
    a_zero_wait: assert property (p_zero_wait)
        else $error("no pready");
    property p_misaligned;
        I_PSEL && !I_PENABLE && I_PADDR[1:0] != 2'b00
            |=> O_PSLVERR && O_PRDATA == 32'h0;
    endproperty
    a_misaligned: assert property (p_misaligned)
        else $error("misaligned not refused");
    property p_upper_zero;
        O_PREADY |-> O_PRDATA[31:8] == 24'h0;
    endproperty
    a_upper_zero: assert property (p_upper_zero)
        else $error("upper data set");
    property p_gain_high;
        wr && a_hi |-> ##2 O_RED_GAIN_CODE[9:2] == $past(I_PWDATA[7:0], 2);
    endproperty
    a_gain_high: assert property (p_gain_high)
        else $error("gain high wrong");
    property p_gain_low;
        wr && a_lo |-> ##2 O_RED_GAIN_CODE[1:0] == $past(I_PWDATA[7:6], 2);
    endproperty
    a_gain_low: assert property (p_gain_low)
        else $error("gain low wrong");
    property p_gain_hold;
        !wr |-> ##2 $stable(O_RED_GAIN_CODE);
    endproperty
    a_gain_hold: assert property (p_gain_hold)
        else $error("gain moved");
    property p_dac_hold;
        !wr |-> ##2 $stable(O_RED_OFFSET_DAC);
    endproperty
    a_dac_hold: assert property (p_dac_hold)
        else $error("dac moved");
    // reset view, disable off
    property p_reset_out;
        disable iff (1'b0) I_SRST ##1 I_SRST |=> !O_PREADY
            && O_RED_GAIN_CODE == 10'h154 && O_RED_OFFSET_DAC == 10'h200;
    endproperty
    a_reset_out: assert property (p_reset_out)
        else $error("bad reset outputs");
endmodule : vafe_regs_sva
bind vafe_regs vafe_regs_sva chk (.*);

// ### vafe_host.sv
/* vafe_host: apb master in place of the host controller.
   assumes: the slave answers with pready. */
`timescale 1ns/100ps
module vafe_host (
    input wire logic i_clock,
    input wire logic i_pready,
    input wire logic [31:0] i_prdata,
    input wire logic i_pslverr,
    output logic o_psel = 1'b0,
    output logic o_penable = 1'b0,
    output logic o_pwrite,
    output logic [11:0] o_paddr,
    output logic [31:0] o_pwdata,
    output logic [3:0] o_pstrb = 4'hf
);
    // one transfer; ok low on timeout
    task automatic xfer(input logic w, input logic [11:0] a,
        input logic [31:0] d, output logic [31:0] q, output logic e,
        output logic ok);
        int n;
        @(posedge i_clock);
        o_psel <= 1'b1;
        o_pwrite <= w;
        o_paddr <= a;
        o_pwdata <= d;
        @(posedge i_clock);
        o_penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge i_clock);
            n++;
        end
        while (i_pready !== 1'b1 && n < 16);
        q = i_prdata;
        e = i_pslverr;
        ok = i_pready === 1'b1;
        o_psel <= 1'b0;
        o_penable <= 1'b0;
    endtask : xfer
endmodule : vafe_host

// ### vafe_regs_tb_top.sv
/* vafe_regs_tb_top: random and corner tests of vafe_regs.
   assumes: vafe_host drives apb; pins driven here. */
`timescale 1ns/100ps
module vafe_regs_tb_top;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic hs = 1'b0, vs = 1'b0, sync_on_green_input = 1'b0, sep = 1'b0, xcl = 1'b0;
    wire logic psel, pen, pwr, pready, pslverr, oh, ov, ocl;
    wire logic [11:0] paddr;
    wire logic [31:0] pwdata, prdata;
    wire logic [3:0] pstrb;
    wire logic [29:0] gn, dc, dg;
    int errors = 0, tests_run = 0;
    logic [7:0] m [0:63]; // expected register contents
    always #2.5 clk = ~clk;
    vafe_host host (.i_clock(clk), .i_pready(pready), .i_prdata(prdata),
        .i_pslverr(pslverr), .o_psel(psel), .o_penable(pen),
        .o_pwrite(pwr), .o_paddr(paddr), .o_pwdata(pwdata),
        .o_pstrb(pstrb));
    vafe_regs uut (.I_CLOCK(clk), .I_SRST(srst), .I_PSEL(psel),
        .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr),
        .I_PWDATA(pwdata), .I_PSTRB(pstrb), .O_PRDATA(prdata),
        .O_PREADY(pready), .O_PSLVERR(pslverr), .I_HSYNC(hs),
        .I_VSYNC(vs), .I_SYNC_ON_GREEN_INPUT(sync_on_green_input),
        .I_SYNC_SEPARATOR(sep), .I_EXTERNAL_CLAMP(xcl), .O_HSYNC(oh),
        .O_VSYNC(ov), .O_CLAMP(ocl), .O_RED_GAIN_CODE(gn[9:0]),
        .O_GREEN_GAIN_CODE(gn[19:10]), .O_BLUE_GAIN_CODE(gn[29:20]),
        .O_RED_OFFSET_DAC(dc[9:0]), .O_GREEN_OFFSET_DAC(dc[19:10]),
        .O_BLUE_OFFSET_DAC(dc[29:20]), .O_RED_DIGITAL_OFFSET(dg[9:0]),
        .O_GREEN_DIGITAL_OFFSET(dg[19:10]),
        .O_BLUE_DIGITAL_OFFSET(dg[29:20]));
    ////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_of_test
    task automatic chk(input string nm, input logic [31:0] ex,
        input logic [31:0] got);
        tests_run++;
        if (got !== ex)
        begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk
    // byte address of a register index
    function automatic logic [11:0] ad(input int i);
        return {2'b00, i[7:0], 2'b00};
    endfunction : ad
    // transfer; a missing answer ends the run
    task automatic xf(input logic w, input logic [11:0] a,
        input logic [7:0] d, output logic [31:0] q, output logic e);
        logic ok;
        host.xfer(w, a, {24'h0, d}, q, e, ok);
        if (!ok)
        begin
            errors++;
            end_of_test();
        end
    endtask : xf
    // channel words against expected registers
    task automatic chk_out(input logic lp);
        logic [9:0] w;
        int b;
        repeat (2) @(posedge clk);
        for (int c = 0; c < 3; c++)
        begin
            b = 8'h12 + 2 * c;
            w = {m[b + 6], m[b + 7][7:6]};
            chk("gain", {m[b], m[b + 1][7:6]}, gn[c * 10 +: 10]);
            chk("dac", lp ? 10'h200 : w, dc[c * 10 +: 10]);
            chk("digital", lp ? w ^ 10'h200 : 10'h0, dg[c * 10 +: 10]);
        end
    endtask : chk_out
    ////////////////////////////////////////////////////////////////////
    initial
    begin
        logic [31:0] q;
        logic e;
        logic [7:0] d;
        int ix;
        void'($urandom(87321));
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        for (int i = 0; i < 14; i++)
            m[i + 16] = vafe_pkg::CFG_RESET[i];
        for (int i = 8'h10; i < 8'h1e; i++)
        begin
            xf(1'b0, ad(i), 8'h0, q, e);
            chk("reset value", m[i], q);
        end
        chk_out(1'b0);
        $display("reset test done");
        // first two writes are full scale
        for (int n = 0; n < 40; n++)
        begin
            ix = n < 2 ? 8'h12 + n : 8'h12 + $urandom_range(11);
            d = n < 2 ? 8'hff : 8'($urandom);
            xf(1'b1, ad(ix), d, q, e);
            m[ix] = ix[0] ? d & 8'hc0 : d;
            xf(1'b0, ad(ix), 8'h0, q, e);
            chk("readback", m[ix], q);
        end
        chk_out(1'b0);
        xf(1'b1, ad(8'h30), 8'h01, q, e);
        chk_out(1'b1);
        $display("gain and offset test done");
        xf(1'b0, ad(8'h20), 8'h0, q, e);
        chk("unmapped error", 1'b1, e);
        chk("unmapped data", 32'h0, q);
        xf(1'b1, 12'h046, 8'h0, q, e);
        chk("misaligned error", 1'b1, e);
        xf(1'b1, ad(8'h31), 8'hff, q, e);
        chk("status write error", 1'b0, e);
        $display("refusal test done");
        for (int k = 0; k < 4; k++)
        begin
            d = {5'h0, k[1:0], 1'b1};
            xf(1'b1, ad(8'h11), d, q, e);
            {hs, vs, sync_on_green_input, sep} <= 4'($urandom);
            repeat (4) @(posedge clk);
            chk("hsync", d[1] ? sync_on_green_input : hs, oh);
            chk("vsync", d[2] ? sep : vs, ov);
        end
        // auto choice: quiet, then only derived lines move
        xf(1'b1, ad(8'h11), 8'h00, q, e);
        {hs, vs, sync_on_green_input, sep} <= 4'h0;
        repeat (4200) @(posedge clk);
        xf(1'b0, ad(8'h31), 8'h0, q, e);
        chk("status quiet", 32'h0, q);
        for (int k = 0; k < 21; k++)
        begin
            {sync_on_green_input, sep} <= ~{sync_on_green_input, sep};
            repeat (10) @(posedge clk);
        end
        xf(1'b0, ad(8'h31), 8'h0, q, e);
        chk("status derived", 32'h33, q);
        chk("auto hsync", sync_on_green_input, oh);
        chk("auto vsync", sep, ov);
        $display("sync test done");
        for (int k = 0; k < 4; k++)
        begin
            xf(1'b1, ad(8'h10), {k[1], 7'h40}, q, e);
            xcl <= k[0];
            repeat (4) @(posedge clk);
            chk("external clamp", k[0] ^ k[1], ocl);
        end
        xf(1'b1, ad(8'h10), 8'h80, q, e);
        sync_on_green_input <= 1'b0;
        repeat (40) @(posedge clk);
        chk("internal clamp", 1'b0, ocl);
        $display("clamp test done");
        end_of_test();
    end
endmodule : vafe_regs_tb_top
